// ---- inc/bric_pkg.sv ----
// shared constants and carriers of the burst rom interface control block
package bric_pkg;

    // register map, byte addresses on the apb
    localparam logic [11:0] BRIC_CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] BRIC_STATUS_OFFSET = 12'h004;
    localparam int          BRIC_ADDR_W        = 12;

    // control register layout, area 1 sits one byte below area 0
    localparam int          BRIC_AREAS         = 2;
    localparam int          BRIC_AREA_STRIDE   = 8;
    localparam int          BRIC_SEL_POS0      = 15;
    localparam int          BRIC_CYC_LSB0      = 12;
    localparam int          BRIC_WORDS_LSB0    = 8;
    localparam int          BRIC_CYC_W         = 3;
    localparam int          BRIC_WORDS_CODE_W  = 2;

    // reset value and writable bits (11, 10, 3, 2 are reserved)
    localparam logic [15:0] BRIC_CTRL_RESET    = 16'h0000;
    localparam logic [15:0] BRIC_WRITE_MASK    = 16'hf3f3;

    // decoded burst figures
    localparam logic [3:0]  BRIC_CYCLES_RESET  = 4'h1;
    localparam logic [5:0]  BRIC_MIN_WORDS     = 6'h04;

    // status register layout
    localparam int          BRIC_STAT_BURST_LSB    = 0;
    localparam int          BRIC_STAT_CONFLICT_LSB = 2;

    // bus interface chosen for one area
    typedef enum logic [1:0] {
        BRIC_MODE_BASIC     = 2'b00,
        BRIC_MODE_BYTE_SRAM = 2'b01,
        BRIC_MODE_BURST_ROM = 2'b10
    } bric_mode_t;

    // configuration handed to the external bus logic for one area
    typedef struct packed {
        bric_mode_t  mode;
        logic [3:0]  burst_cycles;
        logic [5:0]  burst_words;
    } bric_area_cfg_t;

    // apb request from the master
    typedef struct packed {
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [BRIC_ADDR_W-1:0] paddr;
        logic [31:0]            pwdata;
        logic [3:0]             pstrb;
    } bric_apb_req_t;

endpackage : bric_pkg

// ---- src/bric_area_decode.sv ----
`timescale 1ns/1ps
`default_nettype none

// turns one area's control fields into registered bus settings
module bric_area_decode (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    resetn,
    // fields of this area
    input  wire logic                    burst_rom_select,
    input  wire logic [2:0]              burst_cycle_code,
    input  wire logic [1:0]              burst_words_code,
    input  wire logic                    byte_control_sram_select,
    // settings to the external bus logic
    output var  bric_pkg::bric_area_cfg_t cfg_reg,
    output logic                         conflict_reg
);
    import bric_pkg::*;

    bric_area_cfg_t cfg_next;
    logic           conflict_next;

    // burst rom select outranks the byte control sram select
    always_comb begin
        if (burst_rom_select) begin
            cfg_next.mode = BRIC_MODE_BURST_ROM;
        end else if (byte_control_sram_select) begin
            cfg_next.mode = BRIC_MODE_BYTE_SRAM;
        end else begin
            cfg_next.mode = BRIC_MODE_BASIC;
        end
        cfg_next.burst_cycles = {1'b0, burst_cycle_code} + 4'h1;
        cfg_next.burst_words  = 6'(BRIC_MIN_WORDS << burst_words_code);
    end

    // both selects set means software skipped clearing the sram select
    assign conflict_next = burst_rom_select & byte_control_sram_select;

    // registered so the bus logic sees clean levels
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cfg_reg      <= '{BRIC_MODE_BASIC, BRIC_CYCLES_RESET,
                              BRIC_MIN_WORDS};
            conflict_reg <= 1'b0;
        end else begin
            cfg_reg      <= cfg_next;
            conflict_reg <= conflict_next;
        end
    end

endmodule : bric_area_decode

`default_nettype wire

// ---- src/bric_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// Operation
// - bit 15 set puts area 0 on burst rom, clear gives basic or sram.
// - area 0 burst cycle field, bits 14..12, gives field plus one cycles.
// - area 0 words field, bits 9..8, caps a burst at 4,8,16,32 words.
// - bit 7 set puts area 1 on burst rom, clear gives basic or sram.
// - area 1 burst cycle field, bits 6..4, gives field plus one cycles.
// - area 1 words field, bits 1..0, caps a burst at 4,8,16,32 words.
// - bits 11,10,3,2 read zero, ignore writes; all fields reset to zero.
module bric_top (
    // clock and reset
    input  wire logic                       REF_CLK,
    input  wire logic                       RESETN,
    // apb slave
    input  wire bric_pkg::bric_apb_req_t    APB_REQ,
    output logic                            PREADY,
    output logic [31:0]                     PRDATA,
    output logic                            PSLVERR,
    // byte control sram selects of areas 1 and 0
    input  wire logic [1:0]                 AREA_BCSEL,
    // per-area settings, index 0 is area 0
    output var  bric_pkg::bric_area_cfg_t [1:0] AREA_CFG,
    // area interface conflict seen, per area
    output logic [1:0]                      AREA_CONFLICT
);
    import bric_pkg::*;

    // control register and apb answer registers
    logic [15:0] burst_rom_interface_control_reg;
    logic [15:0] burst_rom_interface_control_next;
    logic        pready_reg;
    logic        pready_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pslverr_reg;
    logic        pslverr_next;

    // apb decode
    wire         setup_phase;
    wire         access_done;
    wire         hit_ctrl;
    wire         hit_status;
    wire         hit_any;
    wire         ctrl_write;
    wire [15:0]  lane_mask;
    wire [15:0]  write_mask;
    wire [15:0]  status_word;
    wire [31:0]  read_mux;

    // per-area decoded fields
    wire [1:0]   area_select;
    wire [2:0]   area_cycle_code [BRIC_AREAS];
    wire [1:0]   area_words_code [BRIC_AREAS];
    wire [1:0]   area_burst_active;

    // decoder outputs gathered on nets so each output has a single driver
    wire bric_area_cfg_t [1:0] area_cfg_w;
    wire [1:0]                 area_conflict_w;

    // phase tracking; pready is raised only in the first access cycle
    assign setup_phase = APB_REQ.psel & ~APB_REQ.penable;
    assign access_done = APB_REQ.psel & APB_REQ.penable & pready_reg;

    // address decode, anything else is answered with pslverr
    assign hit_ctrl   = APB_REQ.paddr == BRIC_CTRL_OFFSET;
    assign hit_status = APB_REQ.paddr == BRIC_STATUS_OFFSET;
    assign hit_any    = hit_ctrl | hit_status;

    // byte strobes gate the two low lanes; reserved bits never take data
    assign lane_mask  = {{8{APB_REQ.pstrb[1]}}, {8{APB_REQ.pstrb[0]}}};
    assign write_mask = lane_mask & BRIC_WRITE_MASK;
    assign ctrl_write = access_done & APB_REQ.pwrite & hit_ctrl;

    // merge written lanes into the control word at the completing edge
    assign burst_rom_interface_control_next = ctrl_write ?
        ((burst_rom_interface_control_reg & ~write_mask) |
         (APB_REQ.pwdata[15:0] & write_mask)) :
        burst_rom_interface_control_reg;

    // status shows what the bus logic is really using
    assign status_word = 16'(({14'h0000, AREA_CONFLICT}
                               << BRIC_STAT_CONFLICT_LSB) |
                              ({14'h0000, area_burst_active}
                               << BRIC_STAT_BURST_LSB));

    // read data sampled in setup so it is steady through the access
    assign read_mux = hit_ctrl   ? {16'h0000,
                                    burst_rom_interface_control_reg} :
                      hit_status ? {16'h0000, status_word} :
                                   32'h00000000;

    assign pready_next  = setup_phase;
    assign prdata_next  = (setup_phase & ~APB_REQ.pwrite) ? read_mux :
                                                           32'h00000000;
    assign pslverr_next = setup_phase & ~hit_any;

    // short register processes, all synchronous reset
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            burst_rom_interface_control_reg <= BRIC_CTRL_RESET;
        end else begin
            burst_rom_interface_control_reg <=
                burst_rom_interface_control_next;
        end
    end

    // apb answer; no wait state, pready rises in the first access cycle and prdata still comes from a flop
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign PREADY  = pready_reg;
    assign PRDATA  = prdata_reg;
    assign PSLVERR = pslverr_reg;
    assign AREA_CFG      = area_cfg_w;
    assign AREA_CONFLICT = area_conflict_w;

    // one decoder per area; area a sits a byte lower for each step
    genvar a;
    generate
        for (a = 0; a < BRIC_AREAS; a++) begin : g_area
            // select bit per area
            assign area_select[a] = burst_rom_interface_control_reg[
                BRIC_SEL_POS0 - a*BRIC_AREA_STRIDE];
            // cycle code per area
            assign area_cycle_code[a] = burst_rom_interface_control_reg[
                BRIC_CYC_LSB0 - a*BRIC_AREA_STRIDE +: BRIC_CYC_W];
            // words code per area
            assign area_words_code[a] = burst_rom_interface_control_reg[
                BRIC_WORDS_LSB0 - a*BRIC_AREA_STRIDE +: BRIC_WORDS_CODE_W];
            assign area_burst_active[a] =
                AREA_CFG[a].mode == BRIC_MODE_BURST_ROM;

            // sram select from outside is only trusted when burst is off
            bric_area_decode u_decode (
                .clk                      (REF_CLK),
                .resetn                   (RESETN),
                .burst_rom_select         (area_select[a]),
                .burst_cycle_code         (area_cycle_code[a]),
                .burst_words_code         (area_words_code[a]),
                .byte_control_sram_select (AREA_BCSEL[a]),
                .cfg_reg                  (area_cfg_w[a]),
                .conflict_reg             (area_conflict_w[a])
            );
        end
    endgenerate

    // area 0 interface follows bit 15 one edge later
    AST_A0_SELECT: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        $past(RESETN) |->
            ((AREA_CFG[0].mode == BRIC_MODE_BURST_ROM) ==
             $past(burst_rom_interface_control_reg[15])))
        else $error("area 0 interface does not follow its select bit");

    // area 0 burst length is code plus one
    AST_A0_CYCLES: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        $past(RESETN) |->
            (AREA_CFG[0].burst_cycles ==
             {1'b0, $past(burst_rom_interface_control_reg[14:12])} + 4'h1))
        else $error("area 0 burst cycle count wrong");

    // area 0 word limit for code 3 is four shifted by three, 32 words
    AST_A0_WORDS: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        ($past(RESETN) && $past(burst_rom_interface_control_reg[9:8]) ==
         2'h3) |-> (AREA_CFG[0].burst_words == 6'h20))
        else $error("area 0 word limit for code 3 is not 32");

    // area 1 interface is off burst rom one edge after bit 7 is clear
    AST_A1_SELECT: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        ($past(RESETN) && !$past(burst_rom_interface_control_reg[7])) |->
            (AREA_CFG[1].mode != BRIC_MODE_BURST_ROM))
        else $error("area 1 in burst mode with select clear");

    // area 1 burst length is code plus one
    AST_A1_CYCLES: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        $past(RESETN) |->
            (AREA_CFG[1].burst_cycles ==
             {1'b0, $past(burst_rom_interface_control_reg[6:4])} + 4'h1))
        else $error("area 1 burst cycle count wrong");

    // area 1 word limit, smallest code gives four words
    AST_A1_WORDS: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        ($past(RESETN) && $past(burst_rom_interface_control_reg[1:0]) ==
         2'h0) |-> (AREA_CFG[1].burst_words == 6'h04))
        else $error("area 1 word limit for code 0 is not 4");

    // reserved bits stay zero whatever is written
    AST_RESERVED_ZERO: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        (burst_rom_interface_control_reg & 16'h0c0c) == 16'h0000)
        else $error("reserved control bit became set");

    // after reset both areas start off burst rom
    AST_RESET_STATE: assert property (
        @(posedge REF_CLK)
        !RESETN |=> (burst_rom_interface_control_reg == 16'h0000)
                    ##1 (AREA_CFG[0].mode != BRIC_MODE_BURST_ROM &&
                         AREA_CFG[1].mode != BRIC_MODE_BURST_ROM))
        else $error("control not cleared by reset");

    // a full-width write lands as masked data on the next edge
    AST_WRITE_LANDS: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        (ctrl_write && APB_REQ.pstrb[1:0] == 2'b11) |=>
            (burst_rom_interface_control_reg ==
             ($past(APB_REQ.pwdata[15:0]) & 16'hf3f3)))
        else $error("control write not stored");

    // pready lasts exactly one cycle after each setup
    AST_READY_PULSE: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        setup_phase |=> PREADY ##1 !PREADY)
        else $error("pready not a single cycle after setup");

    // area 0 word limit for every code
    AST_A0_WORDS_ALL: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        $past(RESETN) |->
            (($past(burst_rom_interface_control_reg[9:8]) == 2'h0 &&
              AREA_CFG[0].burst_words == 6'h04) ||
             ($past(burst_rom_interface_control_reg[9:8]) == 2'h1 &&
              AREA_CFG[0].burst_words == 6'h08) ||
             ($past(burst_rom_interface_control_reg[9:8]) == 2'h2 &&
              AREA_CFG[0].burst_words == 6'h10) ||
             ($past(burst_rom_interface_control_reg[9:8]) == 2'h3 &&
              AREA_CFG[0].burst_words == 6'h20)))
        else $error("area 0 word limit does not match its code");

    // area 1 word limit for every code
    AST_A1_WORDS_ALL: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        $past(RESETN) |->
            (($past(burst_rom_interface_control_reg[1:0]) == 2'h0 &&
              AREA_CFG[1].burst_words == 6'h04) ||
             ($past(burst_rom_interface_control_reg[1:0]) == 2'h1 &&
              AREA_CFG[1].burst_words == 6'h08) ||
             ($past(burst_rom_interface_control_reg[1:0]) == 2'h2 &&
              AREA_CFG[1].burst_words == 6'h10) ||
             ($past(burst_rom_interface_control_reg[1:0]) == 2'h3 &&
              AREA_CFG[1].burst_words == 6'h20)))
        else $error("area 1 word limit does not match its code");

    // area 1 set select always means burst rom
    AST_A1_BURST_SET: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        ($past(RESETN) && $past(burst_rom_interface_control_reg[7])) |->
            (AREA_CFG[1].mode == BRIC_MODE_BURST_ROM))
        else $error("area 1 not in burst mode with select set");

    // select clear and sram select set gives byte control sram on area 0
    AST_A0_SRAM_MODE: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        ($past(RESETN) && !$past(burst_rom_interface_control_reg[15]) &&
         $past(AREA_BCSEL[0])) |->
            (AREA_CFG[0].mode == BRIC_MODE_BYTE_SRAM))
        else $error("area 0 not byte control sram with select clear");

    // area 1 conflict flags both selects set one edge earlier
    AST_A1_CONFLICT: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        $past(RESETN) |->
            (AREA_CONFLICT[1] ==
             ($past(burst_rom_interface_control_reg[7]) &&
              $past(AREA_BCSEL[1]))))
        else $error("area 1 conflict flag wrong");

    // an error is only ever shown together with pready
    AST_ERR_WITH_READY: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        PSLVERR |-> PREADY)
        else $error("pslverr raised without pready");

    // read data is zero outside the access cycle
    AST_IDLE_DATA: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        !PREADY |-> (PRDATA == 32'h00000000))
        else $error("prdata not zero outside an access");

    // a control read returns the register with the upper half zero
    AST_CTRL_READ: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        (setup_phase && hit_ctrl && !APB_REQ.pwrite) |=>
            (PRDATA == {16'h0000, $past(burst_rom_interface_control_reg)}))
        else $error("control read data wrong");

    // an unmapped place answers with an error and zero data
    AST_UNMAPPED_ERR: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        (setup_phase && !hit_any) |=>
            (PSLVERR && PRDATA == 32'h00000000))
        else $error("unmapped access not refused");

    // writes to status or an unmapped place leave the control alone
    AST_IGNORED_WRITE: assert property (
        @(posedge REF_CLK) disable iff (!RESETN)
        (access_done && APB_REQ.pwrite && !hit_ctrl) |=>
            $stable(burst_rom_interface_control_reg))
        else $error("write outside the control register landed");

endmodule : bric_top

`default_nettype wire

// ---- verif/bric_rom_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// far side: byte control sram selects as the bus logic sees them
module bric_rom_model (
    // clock
    input  wire logic                           clk,
    // settings from the block, select requests from software
    input  wire bric_pkg::bric_area_cfg_t [1:0] cfg,
    input  wire logic [1:0]                     bcsel_want,
    // selects back to the block
    output logic [1:0]                          bcsel
);
    import bric_pkg::*;

    // sram select is never raised on an area already in burst rom mode
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            bcsel[i] <= bcsel_want[i]
                & (cfg[i].mode != BRIC_MODE_BURST_ROM);
        end
    end
endmodule : bric_rom_model

`default_nettype wire

// ---- verif/burst_rom_area_config_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

// register-level bench of the burst rom area settings
module burst_rom_area_config_tb;
    import bric_pkg::*;

    logic                 ref_clk;
    logic                 resetn;
    bric_apb_req_t        apb_req;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
    logic [1:0]           bcsel;
    logic [1:0]           bcsel_want;
    bric_area_cfg_t [1:0] area_cfg;
    logic [1:0]           area_conflict;
    int                   failures;
    int                   checks_done;
    logic [31:0]          rd;
    logic                 er;
    logic [15:0]          v;
    logic [2:0]           k;

    bric_top dut (
        .REF_CLK       (ref_clk),
        .RESETN        (resetn),
        .APB_REQ       (apb_req),
        .PREADY        (pready),
        .PRDATA        (prdata),
        .PSLVERR       (pslverr),
        .AREA_BCSEL    (bcsel),
        .AREA_CFG      (area_cfg),
        .AREA_CONFLICT (area_conflict)
    );

    bric_rom_model rom (
        .clk        (ref_clk),
        .cfg        (area_cfg),
        .bcsel_want (bcsel_want),
        .bcsel      (bcsel)
    );

    // 250 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one transfer; an edge passes first so psel is never set twice at once
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        apb_req <= '{1'b1, 1'b0, wr, a, d, 4'hf};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        // pready comes from a flop, so its value before the edge is taken
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) check("pready", 32'h1, 32'h0);
        rd = prdata;
        er = pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    // settings trail the register, the select input goes through the model
    task automatic area(input int i, input bric_mode_t m,
                        input logic [2:0] cy, input logic [1:0] w);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check("area mode", 32'(m), 32'(area_cfg[i].mode));
        check("area cycles", 32'(cy) + 1, 32'(area_cfg[i].burst_cycles));
        check("area words", 32'h4 << w, 32'(area_cfg[i].burst_words));
        check("area conflict", 32'h0, 32'(area_conflict[i]));
    endtask : area

    // main sequence
    initial begin
        failures    = 0;
        checks_done = 0;
        resetn      = 1'b0;
        apb_req     = '0;
        bcsel_want  = 2'b00;
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        area(0, BRIC_MODE_BASIC, 3'h0, 2'h0);
        area(1, BRIC_MODE_BASIC, 3'h0, 2'h0);
        apb(1'b0, BRIC_CTRL_OFFSET, 32'h0);
        check("ctrl reset", 32'h0, rd);
        check("ctrl err", 32'h0, 32'(er));
        // every cycle and word code, reserved and upper bits written as ones
        for (int c = 0; c < 8; c++) begin
            k = 3'(c);
            v = {k[0], k, 2'b00, k[1:0], ~k[0], ~k, 2'b00, ~k[1:0]};
            apb(1'b1, BRIC_CTRL_OFFSET, {16'hffff, v | 16'h0c0c});
            apb(1'b0, BRIC_CTRL_OFFSET, 32'h0);
            check("ctrl read", {16'h0, v}, rd);
            area(0, k[0] ? BRIC_MODE_BURST_ROM : BRIC_MODE_BASIC,
                 k, k[1:0]);
            area(1, k[0] ? BRIC_MODE_BASIC : BRIC_MODE_BURST_ROM,
                 ~k, ~k[1:0]);
        end
        apb(1'b0, BRIC_STATUS_OFFSET, 32'h0);
        check("status", 32'h1, rd);
        // unmapped place answers with an error and zero data
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped err", 32'h1, 32'(er));
        check("unmapped data", 32'h0, rd);
        // writes outside the control register change nothing
        apb(1'b1, 12'h008, 32'hffffffff);
        check("unmapped write err", 32'h1, 32'(er));
        apb(1'b1, BRIC_STATUS_OFFSET, 32'hffffffff);
        check("status write err", 32'h0, 32'(er));
        apb(1'b0, BRIC_CTRL_OFFSET, 32'h0);
        check("ctrl kept", 32'h0000f300, rd);
        // burst off: sram selects give byte control sram
        apb(1'b1, BRIC_CTRL_OFFSET, 32'h0);
        @(posedge ref_clk);
        bcsel_want <= 2'b11;
        area(0, BRIC_MODE_BYTE_SRAM, 3'h0, 2'h0);
        area(1, BRIC_MODE_BYTE_SRAM, 3'h0, 2'h0);
        // sram selects dropped first, then burst rom chosen
        @(posedge ref_clk);
        bcsel_want <= 2'b00;
        apb(1'b1, BRIC_CTRL_OFFSET, 32'h8080);
        area(0, BRIC_MODE_BURST_ROM, 3'h0, 2'h0);
        area(1, BRIC_MODE_BURST_ROM, 3'h0, 2'h0);
        apb(1'b0, BRIC_STATUS_OFFSET, 32'h0);
        check("status burst", 32'h3, rd);
        // a reset in mid-run clears the register again
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        apb(1'b0, BRIC_CTRL_OFFSET, 32'h0);
        check("ctrl after reset", 32'h0, rd);
        report_and_stop();
    end

    // a hang ends the run as a failure
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        report_and_stop();
    end
endmodule : burst_rom_area_config_tb

`default_nettype wire
